// *** rtl/fsl_regs.vh ***
`ifndef FSL_REGS_VH
`define FSL_REGS_VH

// Printed offsets of the configuration registers
`define FSL_OFF_PROT_WORD 8'h00
`define FSL_OFF_CODE_LEN 8'h07
`define FSL_OFF_BOOT_LEN 8'h08
// Own registers
`define FSL_OFF_STATUS 8'h10
`define FSL_OFF_CODE_END 8'h11
`define FSL_OFF_BOOT_END 8'h12
`define FSL_OFF_DENY_CNT 8'h13
`define FSL_OFF_LOAD 8'h14

// Unlock pattern and reset value of the protection word
`define FSL_UNLOCK_KEY 32'h5cc5c55c
`define FSL_PROT_RESET 32'h5cc5c55c
// Block size is 512 bytes, so block count shifts left by 9
`define FSL_BLOCK_SHIFT 9
`define FSL_BOOT_ALL 8'h00
// Value returned for a denied debug read
`define FSL_DENY_DATA 32'h00000000

// Memory area codes on the access request ports
`define FSL_AREA_FLASH 3'h0
`define FSL_AREA_SRAM 3'h1
`define FSL_AREA_EEPROM 3'h2
`define FSL_AREA_SIGNATURE_ROW_AREA 3'h3
`define FSL_AREA_USER_ROW_AREA 3'h4
`define FSL_AREA_FUSE 3'h5
`define FSL_AREA_LOCK 3'h6
`define FSL_AREA_REGS 3'h7

// Status register bit positions
`define FSL_ST_UNLOCKED 0
`define FSL_ST_WIPE_EE 1
`define FSL_ST_BOOT_ALL 2

`endif

// *** rtl/fsl_top.v ***
// Functional notes
// - The code-size byte gives boot plus application length in 512-byte blocks.
// - The boot-size byte gives the boot length in 512-byte blocks.
// - A boot-size byte of zero makes the whole Flash boot region.
// - Unlocked only while the protection word equals the unlock pattern.
// - Unlocked debug port reads all areas and writes all but signature row; CPU never writes signature row, fuses or protection word.
// - Locked debug port is denied reads of all areas and writes of all areas but fuse-command writes to the user row.
// - Locked debug port may still write the user row through the fuse command but not read it back.
// - Processor rights do not depend on the lock state.
// - A denied debug read completes silently with data unrelated to contents.
// - The lock is left by a full chip wipe from the external programmer, by reset, or by a load of a protection word equal to the unlock pattern.
// - A wipe on a locked device always erases EEPROM, else the keep bit decides.
`timescale 1ns/1ps
`include "fsl_regs.vh"

module fsl_top #(
    parameter FLASH_BYTES = 65536,
    parameter ADDR_W = 17
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Configuration values loaded from nonvolatile storage
    input wire cfg_load,
    input wire [31:0] cfg_prot_word,
    input wire [7:0] cfg_code_region_length,
    input wire [7:0] cfg_boot_region_length,
    input wire cfg_eeprom_keep_on_wipe,
    // Debug port writes to the protection word and chip wipe
    input wire dbg_prot_wr,
    input wire [31:0] dbg_prot_data,
    input wire dbg_full_chip_wipe,
    // Debug port memory request
    input wire dbg_req,
    input wire dbg_we,
    input wire dbg_fuse_cmd,
    input wire [2:0] dbg_area,
    input wire [31:0] dbg_mem_rdata,
    output reg dbg_grant,
    output reg [31:0] dbg_rdata,
    output reg dbg_rvalid,
    // Processor memory request
    input wire cpu_req,
    input wire cpu_we,
    input wire [2:0] cpu_area,
    output reg cpu_grant,
    // Wipe outcome
    output reg wipe_flash,
    output reg wipe_eeprom,
    // Region boundaries in bytes and lock state
    output reg [ADDR_W-1:0] boot_end,
    output reg [ADDR_W-1:0] code_end,
    output reg device_unlocked,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata
);

////////////////////////////////////////////////////////////////////////
// Stored configuration

reg [31:0] protection_word;
reg [7:0] code_region_length;
reg [7:0] boot_region_length;
reg eeprom_keep_on_wipe;
reg [15:0] deny_count;

wire unlocked = (protection_word == `FSL_UNLOCK_KEY);
wire boot_all = (boot_region_length == `FSL_BOOT_ALL);
wire [ADDR_W-1:0] flash_top = FLASH_BYTES[ADDR_W-1:0];
wire [ADDR_W-1:0] code_bytes =
    {{(ADDR_W-8){1'b0}}, code_region_length} << `FSL_BLOCK_SHIFT;
wire [ADDR_W-1:0] boot_bytes =
    {{(ADDR_W-8){1'b0}}, boot_region_length} << `FSL_BLOCK_SHIFT;
// Whole Flash is boot region when the boot size is zero
wire [ADDR_W-1:0] next_boot_end = boot_all ? flash_top : boot_bytes;
wire [ADDR_W-1:0] next_code_end = boot_all ? flash_top : code_bytes;
// Software loads happen only through cfg_load or the register port load
wire sw_load = reg_wr && (reg_addr == `FSL_OFF_LOAD);

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        protection_word <= `FSL_PROT_RESET;
        code_region_length <= 8'h00;
        boot_region_length <= 8'h00;
        eeprom_keep_on_wipe <= 1'b0;
    end else begin
        if (dbg_full_chip_wipe) begin
            // A wipe restores the unlock pattern, ahead of debug writes and loads
            protection_word <= `FSL_UNLOCK_KEY;
        end else if (dbg_prot_wr && unlocked) begin
            // Any other value written locks the part
            protection_word <= dbg_prot_data;
        end else if (cfg_load || sw_load) begin
            protection_word <= cfg_prot_word;
        end
        if (cfg_load || sw_load) begin
            code_region_length <= cfg_code_region_length;
            boot_region_length <= cfg_boot_region_length;
            eeprom_keep_on_wipe <= cfg_eeprom_keep_on_wipe;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Access decision

reg dbg_ok;
reg cpu_ok;

always @* begin
    dbg_ok = 1'b0;
    if (unlocked) begin
        // Signature row is read-only from the debug port
        dbg_ok = !(dbg_we && dbg_area == `FSL_AREA_SIGNATURE_ROW_AREA);
    end else begin
        // Only user-row writes through the fuse command survive the lock
        dbg_ok = dbg_we && dbg_fuse_cmd &&
            (dbg_area == `FSL_AREA_USER_ROW_AREA);
    end
end

always @* begin
    // Lock state does not enter here
    cpu_ok = 1'b1;
    if (cpu_we && (cpu_area == `FSL_AREA_SIGNATURE_ROW_AREA ||
        cpu_area == `FSL_AREA_FUSE || cpu_area == `FSL_AREA_LOCK)) begin
        cpu_ok = 1'b0;
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        dbg_grant <= 1'b0;
        dbg_rdata <= 32'h00000000;
        dbg_rvalid <= 1'b0;
        cpu_grant <= 1'b0;
        deny_count <= 16'h0000;
    end else begin
        dbg_grant <= dbg_req && dbg_ok;
        cpu_grant <= cpu_req && cpu_ok;
        // Denied reads still complete, so a probe learns nothing
        dbg_rvalid <= dbg_req && !dbg_we;
        if (dbg_req && !dbg_we) begin
            dbg_rdata <= dbg_ok ? dbg_mem_rdata : `FSL_DENY_DATA;
        end
        if (dbg_req && !dbg_ok && deny_count != 16'hffff) begin
            deny_count <= deny_count + 16'h0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Wipe and exported state

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        wipe_flash <= 1'b0;
        wipe_eeprom <= 1'b0;
        boot_end <= {ADDR_W{1'b0}};
        code_end <= {ADDR_W{1'b0}};
        device_unlocked <= 1'b1;
    end else begin
        wipe_flash <= dbg_full_chip_wipe;
        // Locked parts lose EEPROM regardless of the keep bit
        wipe_eeprom <= dbg_full_chip_wipe &&
            (!unlocked || !eeprom_keep_on_wipe);
        boot_end <= next_boot_end;
        code_end <= next_code_end;
        device_unlocked <= unlocked;
    end
end

////////////////////////////////////////////////////////////////////////
// Register port

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
        case (reg_addr)
            `FSL_OFF_PROT_WORD: reg_rdata <= protection_word;
            `FSL_OFF_CODE_LEN: reg_rdata <= {24'h000000, code_region_length};
            `FSL_OFF_BOOT_LEN: reg_rdata <= {24'h000000, boot_region_length};
            `FSL_OFF_STATUS: begin
                reg_rdata <= {29'h00000000, boot_all,
                    !(unlocked && eeprom_keep_on_wipe), unlocked};
            end
            `FSL_OFF_CODE_END: begin
                reg_rdata <= {{(32-ADDR_W){1'b0}}, next_code_end};
            end
            `FSL_OFF_BOOT_END: begin
                reg_rdata <= {{(32-ADDR_W){1'b0}}, next_boot_end};
            end
            `FSL_OFF_DENY_CNT: reg_rdata <= {16'h0000, deny_count};
            default: reg_rdata <= 32'h00000000;
        endcase
    end else begin
        reg_rdata <= 32'h00000000;
    end
end

endmodule // fsl_top

// *** tb/fsl_checker.sv ***
`timescale 1ns/1ps
module fsl_checker (
    // Clock and reset
    input wire core_clk, rst,
    // Debug port
    input wire dbg_req, dbg_we, dbg_fuse_cmd, dbg_grant, dbg_rvalid,
    input wire [2:0] dbg_area,
    input wire [31:0] dbg_mem_rdata, dbg_rdata,
    input wire dbg_full_chip_wipe, wipe_flash, wipe_eeprom, device_unlocked,
    // Processor port
    input wire cpu_req, cpu_we, cpu_grant,
    input wire [2:0] cpu_area
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence rd_s; dbg_req && !dbg_we; endsequence
    sequence uw_s; dbg_req && dbg_we && dbg_fuse_cmd && dbg_area == 3'h4;
    endsequence
    wire cpu_ro = cpu_area == 3'h3 || cpu_area == 3'h5 || cpu_area == 3'h6;
    // Lock state lags the word by one cycle, so look one cycle on
    cpu_grant_a: assert property (
        cpu_req && !(cpu_we && cpu_ro) |=> cpu_grant) else $error("cpu deny");
    cpu_deny_a: assert property (
        cpu_req && cpu_we && cpu_ro |=> !cpu_grant) else $error("cpu grant");
    lock_deny_a: assert property (
        dbg_req && !(dbg_we && dbg_fuse_cmd && dbg_area == 3'h4)
        ##1 !device_unlocked |-> !dbg_grant) else $error("locked grant");
    rvalid_a: assert property (rd_s |=> dbg_rvalid)
        else $error("no rvalid");
    deny_data_a: assert property (
        rd_s ##1 !device_unlocked |-> dbg_rdata == 32'h0)
        else $error("locked data leaked");
    open_read_a: assert property (
        rd_s ##1 device_unlocked |-> dbg_grant && dbg_rdata == $past(dbg_mem_rdata))
        else $error("open read wrong");
    fuse_row_a: assert property (uw_s |=> dbg_grant)
        else $error("user row write refused");
    wipe_open_a: assert property (
        dbg_full_chip_wipe |=> wipe_flash ##1 device_unlocked)
        else $error("wipe did not unlock");
    wipe_ee_a: assert property (
        dbg_full_chip_wipe ##1 !device_unlocked |-> wipe_eeprom)
        else $error("locked wipe kept eeprom");
endmodule // fsl_checker
bind fsl_top fsl_checker u_chk (.*);

// *** tb/fsl_dbg_model.sv ***
`timescale 1ns/1ps
module fsl_dbg_model (
    // Memory view behind the debug port
    input wire [2:0] dbg_area,
    output wire [31:0] dbg_mem_rdata
);
    // Area code in the low bits so data from a wrong area shows up
    assign dbg_mem_rdata = {16'hd0a0, 13'h0, dbg_area};
endmodule // fsl_dbg_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`include "fsl_regs.vh"
module tb_top;
    reg core_clk = 0, rst = 1, cfg_load = 0, cfg_eeprom_keep_on_wipe = 0;
    reg [31:0] cfg_prot_word = 0, dbg_prot_data = 0, reg_wdata = 0;
    reg [7:0] cfg_code_region_length = 0, cfg_boot_region_length = 0;
    reg [7:0] reg_addr = 0;
    reg dbg_prot_wr = 0, dbg_full_chip_wipe = 0, dbg_req = 0, dbg_we = 0;
    reg dbg_fuse_cmd = 0, cpu_req = 0, cpu_we = 0, reg_wr = 0, reg_rd = 0;
    reg [2:0] dbg_area = 0, cpu_area = 0;
    wire [31:0] dbg_mem_rdata, dbg_rdata, reg_rdata;
    wire dbg_grant, dbg_rvalid, cpu_grant, wipe_flash, wipe_eeprom;
    wire device_unlocked;
    wire [16:0] boot_end, code_end;
    integer failures = 0, n_compared = 0, i;
    fsl_top u_dut (.*);
    fsl_dbg_model u_dbg (.*);
    initial forever #25 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    task cmp(input [31:0] got, exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        @(posedge core_clk) begin reg_rd <= 1; reg_addr <= a; end
        @(posedge core_clk) reg_rd <= 0;
        #1 cmp(reg_rdata, exp);
    endtask
    task dbg(input we, fc, input [2:0] a, input g);
        @(posedge core_clk) begin
            dbg_req <= 1; dbg_we <= we; dbg_fuse_cmd <= fc; dbg_area <= a;
        end
        @(posedge core_clk) dbg_req <= 0;
        #1 cmp(dbg_grant, g);
        if (!we) cmp(dbg_rdata, g ? {16'hd0a0, 13'h0, a} : 32'h0);
    endtask
    task cpu(input we, input [2:0] a, input g);
        @(posedge core_clk) begin cpu_req <= 1; cpu_we <= we; cpu_area <= a; end
        @(posedge core_clk) cpu_req <= 0;
        #1 cmp(cpu_grant, g);
    endtask
    // Word write from the debugger; ignored by a locked device
    task key(input [31:0] v);
        @(posedge core_clk) begin dbg_prot_wr <= 1; dbg_prot_data <= v; end
        @(posedge core_clk) dbg_prot_wr <= 0;
    endtask
    task wipe(input ee);
        @(posedge core_clk) dbg_full_chip_wipe <= 1;
        @(posedge core_clk) dbg_full_chip_wipe <= 0;
        #1 cmp({wipe_flash, wipe_eeprom}, {1'b1, ee});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 0;
        rd(`FSL_OFF_PROT_WORD, `FSL_UNLOCK_KEY);
        cfg_boot_region_length <= 8'h04;
        cfg_code_region_length <= 8'h10;
        cfg_eeprom_keep_on_wipe <= 1;
        cfg_prot_word <= `FSL_UNLOCK_KEY;
        @(posedge core_clk) begin reg_wr <= 1; reg_addr <= `FSL_OFF_LOAD; end
        @(posedge core_clk) reg_wr <= 0;
        rd(`FSL_OFF_CODE_LEN, 32'h10);
        rd(`FSL_OFF_CODE_END, 32'h2000);
        rd(`FSL_OFF_BOOT_END, 32'h800);
        rd(`FSL_OFF_STATUS, 32'h1);
        rd(8'h20, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            dbg(0, 0, i[2:0], 1);
            dbg(1, 0, i[2:0], i != 3);
        end
        key(32'h1234abcd);
        rd(`FSL_OFF_STATUS, 32'h2);
        for (i = 0; i < 8; i = i + 1) begin
            dbg(0, 0, i[2:0], 0);
            dbg(1, 0, i[2:0], 0);
            cpu(0, i[2:0], 1);
            cpu(1, i[2:0], !(i == 3 || i == 5 || i == 6));
        end
        dbg(1, 1, 3'h4, 1);
        dbg(0, 0, 3'h4, 0);
        rd(`FSL_OFF_DENY_CNT, 32'h12);
        key(`FSL_UNLOCK_KEY);
        rd(`FSL_OFF_STATUS, 32'h2);
        wipe(1);
        rd(`FSL_OFF_PROT_WORD, `FSL_UNLOCK_KEY);
        wipe(0);
        cfg_boot_region_length <= 8'h00;
        @(posedge core_clk) cfg_load <= 1;
        @(posedge core_clk) cfg_load <= 0;
        rd(`FSL_OFF_STATUS, 32'h5);
        cmp(code_end, 32'h10000);
        cmp(boot_end, 32'h10000);
        report_and_stop;
    end
    // Tests need well under 500 cycles
    initial begin
        #50000;
        failures = failures + 1;
        report_and_stop;
    end
endmodule // tb_top
